// ==== src/cfc_pkg.sv ====
// Constants and types shared by the channel FIFO control logic
package cfc_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the register bus)
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SCRATCH = 8'h08;
	localparam logic [7:0] OFS_UP_LEVEL = 8'h0C;
	localparam logic [7:0] OFS_DN_LEVEL = 8'h10;
	localparam logic [7:0] OFS_FIFO_PORT = 8'h14;

	// ****************************************************************
	// Control register bit positions
	// ****************************************************************
	localparam int BIT_OUTBOUND_RESET = 0;
	localparam int BIT_INBOUND_RESET = 1;
	localparam int BIT_BYPASS = 2;
	localparam int BIT_MASTER_IRQ = 3;
	localparam int BIT_FORCE_IRQ = 4;
	localparam int BIT_OUTBOUND_GO = 16;
	localparam int BIT_INBOUND_GO = 17;
	localparam int BIT_OUTBOUND_EDGE = 18;
	localparam int BIT_INBOUND_EDGE = 19;
	localparam int BIT_OUTBOUND_LEVEL = 21;
	localparam int BIT_INBOUND_LEVEL = 22;
	localparam int BIT_DRIVE_IO = 23;
	localparam int BIT_RECEIVE_SEL = 24;
	localparam logic [31:0] CONTROL_MASK = 32'h01EF001F;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam logic [31:0] SCRATCH_RESET = 32'h00000000;

	// ****************************************************************
	// Status register bit positions and level field
	// ****************************************************************
	localparam int ST_ACTIVE = 31;
	localparam int ST_PREMASK = 30;
	localparam int ST_UP_LATCH = 11;
	localparam int ST_DN_LATCH = 10;
	localparam int ST_UP_FLAGS_LSB = 4;
	localparam int ST_DN_FLAGS_LSB = 0;
	localparam int LEVEL_W = 10;

	// ****************************************************************
	// Default sizes, levels and mover timing
	// ****************************************************************
	localparam int DEF_DEPTH_WORDS = 256;
	localparam int DEF_ALMOST_FULL_WORDS = 192;
	localparam int DEF_ALMOST_EMPTY_WORDS = 64;
	localparam int DEF_SLOW_GAP_CYCLES = 4;
	localparam int LANE_FULL_MARGIN = 2;

	// FIFO flags in status order, full in the top bit
	typedef struct packed {
		logic full;
		logic almost_full;
		logic almost_empty;
		logic empty;
	} cfc_flags_s;

endpackage

// ==== src/cfc_channel_fifo_control.sv ====
// Channel control, status, data-lane FIFOs and movers for one channel
//
// Function
// - Outbound reset holds transmit FIFO and movers
// - Inbound reset holds receive FIFO and movers
// - Bypass moves incoming-lane bytes to outgoing FIFO
// - Bypass disables both external IO paths
// - Master enable gates channel interrupt request out
// - Force bit with master enable requests interrupt
// - Outbound go enables transmit to external IO
// - Inbound go enables receive from external IO
// - Edge latch on transmit FIFO going almost empty
// - Edge latch on receive FIFO going almost full
// - Level interrupt while transmit FIFO almost empty
// - Level interrupt while receive FIFO almost full
// - Drive enable sets transceivers out, terminations off
// - Receive select chooses receivers or bus writes
// - Status bit 31 is masked interrupt active
// - Status bit 30 ORs enabled requests premask
// - Latched bits 11, 10 clear by writing one
// - Status 7..4 show outgoing FIFO flags
// - Status 3..0 show incoming FIFO flags
// - Level registers return word count, bits 9-0
// - Movers burst when safe, else byte-wise
// - Port write pushes word into outgoing FIFO
// - Port read pops word from incoming FIFO
// - Active interrupt drives base pending bit
`timescale 1ns/10ps

// ********************************************************************
// Byte FIFO that takes and gives up to four bytes per clock
// ********************************************************************
module cfc_byte_fifo #(
	parameter int DEPTH = 1024
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	// Write side, caller guarantees room
	input wire logic [2:0] wr_n,
	input wire logic [31:0] wr_data,
	// Read side, caller guarantees content
	input wire logic [2:0] rd_n,
	output logic [31:0] rd_data,
	output logic [$clog2(DEPTH):0] used
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;

	// Storage has no reset so it maps onto block memory
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (i < int'(wr_n)) begin
				mem[wr_ptr + AW'(i)] <= wr_data[8*i +: 8];
			end
		end
	end

	// Pointers and occupancy, clear empties the FIFO
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			used <= '0;
		end else if (clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			used <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(wr_n);
			rd_ptr <= rd_ptr + AW'(rd_n);
			used <= used + (AW+1)'(wr_n) - (AW+1)'(rd_n);
		end
	end

	// Look-ahead of the next four bytes, oldest in the low lane
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rd_data[8*i +: 8] = mem[rd_ptr + AW'(i)];
		end
	end
endmodule

// ********************************************************************
// Channel top
// ********************************************************************
module cfc_channel_fifo_control #(
	parameter int DEPTH_WORDS = cfc_pkg::DEF_DEPTH_WORDS,
	parameter int UP_ALMOST_FULL = cfc_pkg::DEF_ALMOST_FULL_WORDS,
	parameter int UP_ALMOST_EMPTY = cfc_pkg::DEF_ALMOST_EMPTY_WORDS,
	parameter int DN_ALMOST_FULL = cfc_pkg::DEF_ALMOST_FULL_WORDS,
	parameter int DN_ALMOST_EMPTY = cfc_pkg::DEF_ALMOST_EMPTY_WORDS,
	parameter int SLOW_GAP = cfc_pkg::DEF_SLOW_GAP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register bus
	input wire logic [cfc_pkg::ADDR_W-1:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	output logic bus_rvalid,
	// Outgoing data lane toward the controller
	output logic [7:0] up_lane_data,
	output logic up_lane_valid,
	input wire logic up_lane_full,
	input wire logic up_lane_almost_full,
	// Incoming data lane from the controller
	input wire logic [7:0] dn_lane_data,
	input wire logic dn_lane_valid,
	output logic dn_lane_full,
	output logic dn_lane_almost_full,
	// External IO
	output logic [7:0] tx_byte,
	output logic tx_strobe,
	input wire logic [7:0] rx_byte,
	input wire logic rx_strobe,
	output logic io_drive_enable,
	output logic io_termination_enable,
	// Interrupt request toward the base pending bit
	output logic irq_request
);
	localparam int DEPTH = 4 * DEPTH_WORDS;
	localparam int CW = $clog2(DEPTH) + 1;
	localparam logic [CW-1:0] ONE_BYTE = CW'(1);
	localparam logic [CW-1:0] ONE_WORD = CW'(4);

	// Word count of a byte occupancy
	function automatic logic [cfc_pkg::LEVEL_W-1:0] words(
		input logic [CW-1:0] used_bytes);
		words = cfc_pkg::LEVEL_W'(used_bytes >> 2);
	endfunction

	// Flags from an occupancy and programmed word levels
	function automatic cfc_pkg::cfc_flags_s flags_of(
		input logic [CW-1:0] used_bytes, input int af, input int ae);
		cfc_pkg::cfc_flags_s f;
		f.full = (used_bytes == CW'(DEPTH));
		f.almost_full = (int'(words(used_bytes)) >= af);
		f.almost_empty = (int'(words(used_bytes)) <= ae);
		f.empty = (used_bytes == '0);
		flags_of = f;
	endfunction

	logic [31:0] control;
	logic [31:0] scratch;
	logic up_latch;
	logic dn_latch;
	logic up_af_prev;
	logic dn_ae_prev;
	logic [7:0] gap;
	logic [7:0] rx_byte_meta;
	logic [7:0] rx_byte_sync;
	logic rx_strobe_meta;
	logic rx_strobe_sync;
	logic rx_strobe_prev;

	logic [2:0] up_wr_n;
	logic [31:0] up_wr_data;
	logic [2:0] up_rd_n;
	logic [31:0] up_peek;
	logic [CW-1:0] up_used;
	logic [2:0] dn_wr_n;
	logic [2:0] dn_rd_n;
	logic [31:0] dn_peek;
	logic [CW-1:0] dn_used;
	cfc_pkg::cfc_flags_s up_flags;
	cfc_pkg::cfc_flags_s dn_flags;
	logic [31:0] status;
	logic out_rst;
	logic in_rst;
	logic bypass;
	logic tx_path;
	logic rx_path;
	logic rx_take;
	logic port_push;
	logic port_pop;
	logic bypass_move;
	logic tx_move;
	logic up_move;
	logic premask;
	logic active;
	logic up_latch_set;
	logic dn_latch_set;
	logic status_wr;

	// ****************************************************************
	// Control decode
	// ****************************************************************
	// transmit side reset
	assign out_rst = control[cfc_pkg::BIT_OUTBOUND_RESET];
	assign in_rst = control[cfc_pkg::BIT_INBOUND_RESET];
	assign bypass = control[cfc_pkg::BIT_BYPASS];
	// transmit IO only when started and not bypassed
	assign tx_path = control[cfc_pkg::BIT_OUTBOUND_GO] & ~bypass;
	// receivers feed the FIFO only when selected
	assign rx_path = control[cfc_pkg::BIT_INBOUND_GO] & ~bypass
		& control[cfc_pkg::BIT_RECEIVE_SEL];

	// flags from word counts against levels
	assign up_flags = flags_of(up_used, UP_ALMOST_FULL, UP_ALMOST_EMPTY);
	assign dn_flags = flags_of(dn_used, DN_ALMOST_FULL, DN_ALMOST_EMPTY);

	// ****************************************************************
	// External receive synchroniser
	// ****************************************************************
	// Receiver pins are asynchronous, two flops before any use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_byte_meta <= 8'h00;
			rx_byte_sync <= 8'h00;
			rx_strobe_meta <= 1'b0;
			rx_strobe_sync <= 1'b0;
			rx_strobe_prev <= 1'b0;
		end else begin
			rx_byte_meta <= rx_byte;
			rx_byte_sync <= rx_byte_meta;
			rx_strobe_meta <= rx_strobe;
			rx_strobe_sync <= rx_strobe_meta;
			rx_strobe_prev <= rx_strobe_sync;
		end
	end
	assign rx_take = rx_strobe_sync & ~rx_strobe_prev;

	// ****************************************************************
	// Data path selection
	// ****************************************************************
	// bus writes feed the outgoing FIFO unless receivers do
	assign port_push = bus_write & (bus_addr == cfc_pkg::OFS_FIFO_PORT)
		& ~in_rst & ~rx_path & (up_used <= CW'(DEPTH) - ONE_WORD);
	// a read pops only a whole word
	assign port_pop = bus_read & (bus_addr == cfc_pkg::OFS_FIFO_PORT)
		& ~out_rst & (dn_used >= ONE_WORD);
	// loop-back byte when both sides can take it
	assign bypass_move = bypass & ~port_push & ~port_pop & ~in_rst
		& ~out_rst & (dn_used >= ONE_BYTE) & ~up_flags.full;
	// transmit one byte per clock toward the external IO
	assign tx_move = tx_path & ~port_pop & ~out_rst
		& (dn_used >= ONE_BYTE);
	// outgoing lane mover obeys partner full and the gap
	assign up_move = ~in_rst & (up_used >= ONE_BYTE) & ~up_lane_full
		& (gap == 8'h00);

	// Outgoing FIFO write source, one source per clock
	always_comb begin
		up_wr_n = 3'd0;
		up_wr_data = 32'h00000000;
		if (port_push) begin
			up_wr_n = 3'd4;
			up_wr_data = bus_wdata;
		end else if (bypass_move) begin
			up_wr_n = 3'd1;
			up_wr_data = {24'h000000, dn_peek[7:0]};
		end else if (rx_path & rx_take & ~in_rst & ~up_flags.full) begin
			up_wr_n = 3'd1;
			up_wr_data = {24'h000000, rx_byte_sync};
		end
	end

	assign up_rd_n = up_move ? 3'd1 : 3'd0;
	assign dn_rd_n = port_pop ? 3'd4
		: ((bypass_move | tx_move) ? 3'd1 : 3'd0);
	// Incoming lane bytes beyond capacity are dropped
	assign dn_wr_n = (dn_lane_valid & ~out_rst & ~dn_flags.full)
		? 3'd1 : 3'd0;

	// outgoing FIFO cleared while receive reset holds
	cfc_byte_fifo #(.DEPTH(DEPTH)) up_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clear(in_rst),
		.wr_n(up_wr_n),
		.wr_data(up_wr_data),
		.rd_n(up_rd_n),
		.rd_data(up_peek),
		.used(up_used)
	);

	// incoming FIFO cleared while transmit reset holds
	cfc_byte_fifo #(.DEPTH(DEPTH)) dn_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clear(out_rst),
		.wr_n(dn_wr_n),
		.wr_data({24'h000000, dn_lane_data}),
		.rd_n(dn_rd_n),
		.rd_data(dn_peek),
		.used(dn_used)
	);

	// ****************************************************************
	// Lane movers and IO outputs
	// ****************************************************************
	// burst when safe, else wait a gap for fresh status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			up_lane_data <= 8'h00;
			up_lane_valid <= 1'b0;
			gap <= 8'h00;
		end else if (in_rst) begin
			up_lane_valid <= 1'b0;
			gap <= 8'h00;
		end else begin
			up_lane_valid <= up_move;
			if (up_move) begin
				up_lane_data <= up_peek[7:0];
			end
			if (up_move & (up_flags.almost_empty | up_lane_almost_full)) begin
				gap <= 8'(SLOW_GAP);
			end else if (gap != 8'h00) begin
				gap <= gap - 8'h01;
			end
		end
	end

	// Flow control back to the partner, margin covers one flop delay
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dn_lane_full <= 1'b1;
			dn_lane_almost_full <= 1'b1;
		end else begin
			dn_lane_full <= out_rst
				| (dn_used >= CW'(DEPTH - cfc_pkg::LANE_FULL_MARGIN));
			dn_lane_almost_full <= out_rst | dn_flags.almost_full;
		end
	end

	// transmit byte strobe toward the external drivers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_byte <= 8'h00;
			tx_strobe <= 1'b0;
		end else begin
			tx_strobe <= tx_move;
			if (tx_move) begin
				tx_byte <= dn_peek[7:0];
			end
		end
	end

	// drive outward with terminations off, never in bypass
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_drive_enable <= 1'b0;
			io_termination_enable <= 1'b1;
		end else begin
			io_drive_enable <= control[cfc_pkg::BIT_DRIVE_IO] & ~bypass;
			io_termination_enable <= ~(control[cfc_pkg::BIT_DRIVE_IO]
				& ~bypass);
		end
	end

	// ****************************************************************
	// Interrupt logic
	// ****************************************************************
	// enabled transitions into the almost states
	assign dn_latch_set = control[cfc_pkg::BIT_OUTBOUND_EDGE]
		& dn_flags.almost_empty & ~dn_ae_prev;
	assign up_latch_set = control[cfc_pkg::BIT_INBOUND_EDGE]
		& up_flags.almost_full & ~up_af_prev;
	assign status_wr = bus_write & (bus_addr == cfc_pkg::OFS_STATUS);

	// Previous flags for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			up_af_prev <= 1'b0;
			dn_ae_prev <= 1'b1;
		end else begin
			up_af_prev <= up_flags.almost_full;
			dn_ae_prev <= dn_flags.almost_empty;
		end
	end

	// write one clears, a same-cycle event wins over the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			up_latch <= 1'b0;
			dn_latch <= 1'b0;
		end else begin
			up_latch <= in_rst ? 1'b0 : (up_latch_set | (up_latch
				& ~(status_wr & bus_wdata[cfc_pkg::ST_UP_LATCH])));
			dn_latch <= out_rst ? 1'b0 : (dn_latch_set | (dn_latch
				& ~(status_wr & bus_wdata[cfc_pkg::ST_DN_LATCH])));
		end
	end

	// every enabled request before the master mask
	assign premask = (up_latch & control[cfc_pkg::BIT_INBOUND_EDGE])
		| (dn_latch & control[cfc_pkg::BIT_OUTBOUND_EDGE])
		| (control[cfc_pkg::BIT_OUTBOUND_LEVEL] & dn_flags.almost_empty)
		| (control[cfc_pkg::BIT_INBOUND_LEVEL] & up_flags.almost_full)
		| control[cfc_pkg::BIT_FORCE_IRQ];
	// masked by the channel master enable
	assign active = premask & control[cfc_pkg::BIT_MASTER_IRQ];

	// the base gathers this into its pending bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= active;
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	// control clears on reset, reserved bits stay zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			control <= cfc_pkg::CONTROL_RESET;
			scratch <= cfc_pkg::SCRATCH_RESET;
		end else if (bus_write) begin
			if (bus_addr == cfc_pkg::OFS_CONTROL) begin
				control <= bus_wdata & cfc_pkg::CONTROL_MASK;
			end
			if (bus_addr == cfc_pkg::OFS_SCRATCH) begin
				scratch <= bus_wdata;
			end
		end
	end

	always_comb begin
		status = 32'h00000000;
		status[cfc_pkg::ST_ACTIVE] = active;
		status[cfc_pkg::ST_PREMASK] = premask;
		status[cfc_pkg::ST_UP_LATCH] = up_latch;
		status[cfc_pkg::ST_DN_LATCH] = dn_latch;
		status[cfc_pkg::ST_UP_FLAGS_LSB +: 4] = up_flags;
		status[cfc_pkg::ST_DN_FLAGS_LSB +: 4] = dn_flags;
	end

	// read data one clock after the strobe, unmapped reads 0
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 32'h00000000;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_read;
			if (bus_read) begin
				case (bus_addr)
					cfc_pkg::OFS_CONTROL: bus_rdata <= control;
					cfc_pkg::OFS_STATUS: bus_rdata <= status;
					cfc_pkg::OFS_SCRATCH: bus_rdata <= scratch;
					cfc_pkg::OFS_UP_LEVEL: bus_rdata <= {22'h000000,
						words(up_used)};
					cfc_pkg::OFS_DN_LEVEL: bus_rdata <= {22'h000000,
						words(dn_used)};
					cfc_pkg::OFS_FIFO_PORT: bus_rdata <= dn_peek;
					default: bus_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ==== verification/cfc_channel_props.sv ====
// Port-level assertions for the channel FIFO control block
`timescale 1ns/10ps
module cfc_channel_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register bus
	input wire logic [cfc_pkg::ADDR_W-1:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_rvalid,
	// Lanes, IO and interrupt
	input wire logic up_lane_valid,
	input wire logic dn_lane_full,
	input wire logic tx_strobe,
	input wire logic io_drive_enable,
	input wire logic io_termination_enable,
	input wire logic irq_request
);
	logic [31:0] ctl;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ****************************************************************
	// Control shadow
	// ****************************************************************
	// Rebuilt from bus writes; the register is not a port
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= 32'h0;
		end else if (bus_write && bus_addr == cfc_pkg::OFS_CONTROL) begin
			ctl <= bus_wdata & cfc_pkg::CONTROL_MASK;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Read request followed by its answer
	sequence s_rd(logic [7:0] a);
		bus_read && bus_addr == a ##1 bus_rvalid;
	endsequence
	chk_ctl_readback:
		assert property (s_rd(cfc_pkg::OFS_CONTROL) |-> bus_rdata == $past(ctl))
		else $error("control readback differs from last write");
	chk_status_active:
		assert property (s_rd(cfc_pkg::OFS_STATUS)
			|-> bus_rdata[31] == (bus_rdata[30] && $past(ctl[3])))
		else $error("active bit not premask and master enable");
	chk_status_flags:
		assert property (s_rd(cfc_pkg::OFS_STATUS)
			|-> (!bus_rdata[7] || bus_rdata[6]) && (!bus_rdata[4] || bus_rdata[5])
			&& (!bus_rdata[3] || bus_rdata[2]) && (!bus_rdata[0] || bus_rdata[1]))
		else $error("fifo flags inconsistent");
	chk_level_upper:
		assert property (s_rd(cfc_pkg::OFS_UP_LEVEL) |-> bus_rdata[31:10] == 22'h0)
		else $error("level upper bits not zero");
	chk_drive_io:
		assert property (io_drive_enable == $past(ctl[23] && !ctl[2]))
		else $error("drive enable wrong");
	chk_term_inverse:
		assert property (io_termination_enable != io_drive_enable)
		else $error("termination equals drive");
	chk_irq_mask:
		assert property (irq_request |-> $past(ctl[3]))
		else $error("request without master enable");
	chk_force_irq:
		assert property (ctl[3] && ctl[4] |=> irq_request)
		else $error("forced request missing");
	chk_tx_gate:
		assert property (tx_strobe |-> $past(ctl[16] && !ctl[2] && !ctl[0]))
		else $error("tx byte while transmit not allowed");
	chk_out_reset:
		assert property (ctl[0] |=> dn_lane_full)
		else $error("incoming lane not held full");
	chk_in_reset:
		assert property (ctl[1] |=> !up_lane_valid)
		else $error("outgoing byte during inbound reset");
	chk_rvalid_pulse:
		assert property (bus_rvalid == $past(bus_read))
		else $error("read answer timing wrong");
endmodule

bind cfc_channel_fifo_control cfc_channel_props u_cfc_channel_props (.*);

// ==== verification/cfc_lane_partner.sv ====
// Behavioural bus controller side of the two data lanes
`timescale 1ns/10ps
module cfc_lane_partner (
	// Clock and test control
	input wire logic clk,
	input wire logic stall,
	// Outgoing lane seen from the far side
	input wire logic [7:0] up_lane_data,
	input wire logic up_lane_valid,
	output logic up_lane_full,
	output logic up_lane_almost_full,
	// Incoming lane driven by the far side
	output logic [7:0] dn_lane_data,
	output logic dn_lane_valid,
	input wire logic dn_lane_full,
	input wire logic dn_lane_almost_full
);
	logic [7:0] got_q[$];
	logic [7:0] send_q[$];
	int gap = 0;
	// Stall plays a full target
	assign up_lane_full = stall;
	initial begin
		dn_lane_data = 8'h00;
		dn_lane_valid = 1'b0;
		up_lane_almost_full = 1'b0;
	end
	task automatic send_byte(input logic [7:0] b);
		send_q.push_back(b);
	endtask
	// Collect bytes; later half of a long drain is answered slowly
	always @(posedge clk) begin
		if (up_lane_valid === 1'b1) begin
			got_q.push_back(up_lane_data);
		end
		up_lane_almost_full <= stall || (got_q.size() % 64 >= 32);
	end
	// burst when safe, else one byte then a settling gap
	always @(posedge clk) begin
		#1;
		if (gap == 0 && send_q.size() > 0 && dn_lane_full === 1'b0) begin
			dn_lane_valid = 1'b1;
			dn_lane_data = send_q.pop_front();
			if (dn_lane_almost_full !== 1'b0 || send_q.size() < 4) begin
				gap = 4;
			end
		end else begin
			// Idle data toggles so stale bytes never look valid
			dn_lane_valid = 1'b0;
			dn_lane_data = ~dn_lane_data;
			gap = (gap > 0) ? gap - 1 : 0;
		end
	end
endmodule

// ==== verification/tb_top.sv ====
// Register-level testbench of the channel FIFO control block
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [cfc_pkg::ADDR_W-1:0] bus_addr;
	logic bus_write;
	logic bus_read;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic [31:0] v;
	logic [7:0] up_lane_data, dn_lane_data, tx_byte;
	logic [7:0] rx_byte;
	logic rx_strobe;
	logic stall;
	logic bus_rvalid, up_lane_valid, up_lane_full, up_lane_almost_full;
	logic dn_lane_valid, dn_lane_full, dn_lane_almost_full;
	logic tx_strobe, io_drive_enable, io_termination_enable, irq_request;
	logic [7:0] tx_q[$];
	int miscompares = 0;
	int samples_checked = 0;
	// Interrupt table: control value and the status it gives
	logic [31:0] irq_ctl[5] = '{32'h10, 32'h18, 32'h200000, 32'h200008,
		32'h400008};
	logic [31:0] irq_st[5] = '{32'h40000033, 32'hC0000033, 32'h40000033,
		32'hC0000033, 32'h33};

	cfc_channel_fifo_control #(.DEPTH_WORDS(16), .UP_ALMOST_FULL(12),
		.UP_ALMOST_EMPTY(4), .DN_ALMOST_FULL(12), .DN_ALMOST_EMPTY(4),
		.SLOW_GAP(4)) u_cfc_channel_fifo_control (.*);
	cfc_lane_partner u_cfc_lane_partner (.*);

	initial begin
		forever #5 clk = ~clk;
	end
	// Capture bytes sent to the drivers
	always @(posedge clk) begin
		if (tx_strobe === 1'b1) begin
			tx_q.push_back(tx_byte);
		end
	end

	// ****************************************************************
	// Bus tasks and checks
	// ****************************************************************
	task automatic print_verdict();
		$display("checked=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		bus_addr = a;
		bus_wdata = d;
		bus_write = 1'b1;
		@(posedge clk);
		#1;
		bus_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		#1;
		bus_addr = a;
		bus_read = 1'b1;
		@(posedge clk);
		#1;
		bus_read = 1'b0;
		for (n = 0; n < 4 && bus_rvalid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 4) begin
			miscompares++;
			print_verdict();
		end
		d = bus_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// Bounded waits on the far side
	task automatic wait_rx(input int n);
		int i;
		for (i = 0; i < 2000 && u_cfc_lane_partner.got_q.size() < n; i++) begin
			@(posedge clk);
		end
		if (i == 2000) begin
			miscompares++;
			print_verdict();
		end
	endtask
	task automatic wait_sent();
		int i;
		for (i = 0; i < 500 && u_cfc_lane_partner.send_q.size() > 0; i++) begin
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask
	task automatic chk_got(input int s, input int n, input logic [7:0] f);
		for (int i = 0; i < n; i++) begin
			chk({24'h0, u_cfc_lane_partner.got_q[s+i]}, {24'h0, f + 8'(i)});
		end
	endtask
	task automatic send_seq(input int n, input logic [7:0] f);
		for (int i = 0; i < n; i++) begin
			u_cfc_lane_partner.send_byte(f + 8'(i));
		end
		wait_sent();
	endtask
	function automatic logic [31:0] w4(input int k);
		return 32'h03020100 + 32'(k) * 32'h04040404;
	endfunction

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		{bus_write, bus_read, rx_strobe, stall} = 4'h0;
		{bus_addr, rx_byte, bus_wdata} = 48'h0;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		rc(cfc_pkg::OFS_CONTROL, 32'h0);
		rc(cfc_pkg::OFS_STATUS, 32'h33);
		chk({31'h0, io_termination_enable}, 32'h1);
		wr(cfc_pkg::OFS_CONTROL, 32'hFFFFFFFF);
		rc(cfc_pkg::OFS_CONTROL, cfc_pkg::CONTROL_MASK);
		wr(cfc_pkg::OFS_SCRATCH, 32'hA55A3CC3);
		rc(cfc_pkg::OFS_SCRATCH, 32'hA55A3CC3);
		rc(8'h18, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			wr(cfc_pkg::OFS_CONTROL, irq_ctl[i]);
			rc(cfc_pkg::OFS_STATUS, irq_st[i]);
			chk({31'h0, irq_request}, {31'h0, irq_st[i][31]});
		end
		wr(cfc_pkg::OFS_CONTROL, 32'h800000);
		rc(cfc_pkg::OFS_CONTROL, 32'h800000);
		chk({31'h0, io_drive_enable}, 32'h1);
		wr(cfc_pkg::OFS_CONTROL, 32'h800004);
		rc(cfc_pkg::OFS_CONTROL, 32'h800004);
		chk({31'h0, io_drive_enable}, 32'h0);
		$display("test interrupts and io done");
		// outgoing fill past full, then drain
		wr(cfc_pkg::OFS_CONTROL, 32'h80000);
		stall = 1'b1;
		for (int k = 0; k < 17; k++) begin
			wr(cfc_pkg::OFS_FIFO_PORT, w4(k));
		end
		rc(cfc_pkg::OFS_UP_LEVEL, 32'h10);
		rc(cfc_pkg::OFS_STATUS, 32'h400008C3);
		wr(cfc_pkg::OFS_STATUS, 32'h800);
		rc(cfc_pkg::OFS_STATUS, 32'hC3);
		stall = 1'b0;
		wait_rx(64);
		chk_got(0, 64, 8'h00);
		rc(cfc_pkg::OFS_UP_LEVEL, 32'h0);
		stall = 1'b1;
		wr(cfc_pkg::OFS_FIFO_PORT, w4(0));
		wr(cfc_pkg::OFS_CONTROL, 32'h2);
		wr(cfc_pkg::OFS_FIFO_PORT, w4(1));
		rc(cfc_pkg::OFS_UP_LEVEL, 32'h0);
		wr(cfc_pkg::OFS_CONTROL, 32'h0);
		stall = 1'b0;
		repeat (40) @(posedge clk);
		chk(u_cfc_lane_partner.got_q.size(), 32'd64);
		$display("test outgoing fifo done");
		// incoming fill, pop through almost empty
		wr(cfc_pkg::OFS_CONTROL, 32'h40000);
		send_seq(24, 8'h00);
		rc(cfc_pkg::OFS_DN_LEVEL, 32'h6);
		rc(cfc_pkg::OFS_STATUS, 32'h30);
		for (int k = 0; k < 6; k++) begin
			rd(cfc_pkg::OFS_FIFO_PORT, v);
			chk(v, w4(k));
		end
		rc(cfc_pkg::OFS_STATUS, 32'h40000433);
		wr(cfc_pkg::OFS_STATUS, 32'h400);
		rc(cfc_pkg::OFS_STATUS, 32'h33);
		send_seq(8, 8'h10);
		wr(cfc_pkg::OFS_CONTROL, 32'h1);
		rc(cfc_pkg::OFS_DN_LEVEL, 32'h0);
		$display("test incoming fifo done");
		// bypass loops lane bytes back out
		wr(cfc_pkg::OFS_CONTROL, 32'h4);
		send_seq(4, 8'hA0);
		wait_rx(68);
		chk_got(64, 4, 8'hA0);
		wr(cfc_pkg::OFS_CONTROL, 32'h10000);
		send_seq(2, 8'h5A);
		chk(tx_q.size(), 32'd2);
		chk({24'h0, tx_q[0]}, 32'h5A);
		chk({24'h0, tx_q[1]}, 32'h5B);
		// receivers feed outgoing fifo; bus writes refused
		wr(cfc_pkg::OFS_CONTROL, 32'h1020000);
		wr(cfc_pkg::OFS_FIFO_PORT, w4(3));
		rc(cfc_pkg::OFS_UP_LEVEL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			rx_byte = 8'hC0 + 8'(i);
			repeat (2) @(posedge clk);
			#1;
			rx_strobe = 1'b1;
			repeat (4) @(posedge clk);
			#1;
			rx_strobe = 1'b0;
			repeat (2) @(posedge clk);
		end
		wait_rx(72);
		chk_got(68, 4, 8'hC0);
		$display("test paths done");
		print_verdict();
	end
endmodule
